/* verilog/pfc_top.sv */
// Contract
// - Global fault flag in both status words when any fault latched.
// - Undervoltage flag when logic or regulator supply dropped since fault reset.
// - Logic-reset flag set by power-on or reset pin low; cleared by a read.
// - Overtemperature flag when overtemperature seen since fault reset.
// - Identifier bit is 0 in the low-channel word, 1 in the high.
// - Each channel reports short-to-ground, short-to-battery and open-load flags.
// - Word with bit 15 set configures channel selected by bits 14..12.
// - Channel select is binary; codes 0 to 5 address channels 0 to 5.
// - Retry select: upper bit 0 locks out; 10 short retry; 11 long.
// - Pull-down on when its disable bit is 0, off when 1.
// - Turn-off blanking select gives 80, 140, 280 us or 4 ms.
// - Turn-on blanking select gives 5, 14, 28 or 56 us.
// - Battery-short threshold select, 6 to 18 percent steps, top code 7.
// - Ground-short threshold select: 0 is 45 percent, 1 is 66 percent.
// - Power-on reset clears every per-channel configuration field.
// - Masked channel ignores all faults and reports none.
// - Open-load mask disables open-load diagnosis where pull-down disabled.
// - Gate high only with request set, reset pin high, channel not blocked by a battery short.
module pfc_top #(
  parameter int TOF1_CYC = pfc_pkg::TOF1_CYC,
  parameter int TOF2_CYC = pfc_pkg::TOF2_CYC,
  parameter int TOF3_CYC = pfc_pkg::TOF3_CYC,
  parameter int RETRY_SHORT_CYC = pfc_pkg::RETRY_SHORT_CYC,
  parameter int RETRY_LONG_CYC = pfc_pkg::RETRY_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active_low_reset_in,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic read_valid,
  input wire logic read_sel,
  output logic [15:0] read_data,
  input wire logic uv_logic_in,
  input wire logic uv_regulator_in,
  input wire logic overtemp_in,
  input wire logic [5:0] cmp_short_gnd,
  input wire logic [5:0] cmp_short_bat,
  input wire logic [5:0] cmp_open_load,
  output logic [5:0] driver_output,
  output logic [5:0] pulldown_en,
  output logic [5:0] open_load_diag_en,
  output logic [17:0] shortbat_thresh_sel,
  output logic [5:0] shortgnd_thresh_sel
);
  localparam int N = pfc_pkg::N_CHAN;
  localparam int W = pfc_pkg::CNT_W;
  localparam int SW = 4 + 3 * N;

  if (TOF1_CYC < 1 || TOF2_CYC < 1 || TOF3_CYC < 1) begin : g_bad_tof
    $error("Blanking counts must be at least one cycle");
  end
  if (RETRY_SHORT_CYC < 1 || RETRY_LONG_CYC >= 2 ** W) begin : g_bad_retry
    $error("Retry counts out of counter range");
  end
  if (TOF3_CYC >= 2 ** W) begin : g_bad_tof3
    $error("Blanking count out of counter range");
  end
  // Both retry counts must be at least one cycle and fit the counter
  if (RETRY_SHORT_CYC >= 2 ** W || RETRY_LONG_CYC < 1) begin : g_bad_retry_rng
    $error("Retry counts out of counter range");
  end

  localparam logic [W-1:0] TON_TAB [4] = '{
    W'(pfc_pkg::TON0_CYC), W'(pfc_pkg::TON1_CYC),
    W'(pfc_pkg::TON2_CYC), W'(pfc_pkg::TON3_CYC)
  };
  localparam logic [W-1:0] TOF_TAB [4] = '{
    W'(pfc_pkg::TOF0_CYC), W'(TOF1_CYC), W'(TOF2_CYC), W'(TOF3_CYC)
  };
  localparam logic [W-1:0] RETRY_SHORT_LEN = W'(RETRY_SHORT_CYC);
  localparam logic [W-1:0] RETRY_LONG_LEN = W'(RETRY_LONG_CYC);

  // Pins from the analog side all pass two flops
  logic [SW-1:0] pins_w;
  logic [SW-1:0] pins_s;
  logic ext_rst_n_s;
  logic uv_logic_s;
  logic uv_reg_s;
  logic ot_s;
  logic [5:0] sg_s;
  logic [5:0] sb_s;
  logic [5:0] ol_s;

  assign pins_w = {active_low_reset_in, uv_logic_in, uv_regulator_in, overtemp_in,
                   cmp_short_gnd, cmp_short_bat, cmp_open_load};

  pfc_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_w),
    .q(pins_s)
  );

  assign {ext_rst_n_s, uv_logic_s, uv_reg_s, ot_s, sg_s, sb_s, ol_s} = pins_s;

  // Reset pin low acts as the fault reset
  logic clr_w;
  assign clr_w = ~ext_rst_n_s;

  // Word decode
  logic cfg_we_w;
  logic gate_we_w;
  logic mask_we_w;
  logic [2:0] adr_w;
  logic [3:0] hdr_w;
  pfc_pkg::pfc_cfg_s cfg_word_w;

  assign hdr_w = word_data[pfc_pkg::HDR_LSB +: 4];
  assign adr_w = word_data[pfc_pkg::ADR_LSB +: 3];
  assign cfg_we_w = word_valid & word_data[pfc_pkg::CMD_BIT];
  assign gate_we_w = word_valid & (hdr_w == pfc_pkg::HDR_GATE);
  assign mask_we_w = word_valid & (hdr_w == pfc_pkg::HDR_MASK);
  assign cfg_word_w.retry_select = word_data[pfc_pkg::RT_LSB +: 2];
  assign cfg_word_w.pulldown_disable = word_data[pfc_pkg::NPD_BIT];
  assign cfg_word_w.turnoff_blank_sel = word_data[pfc_pkg::TOF_LSB +: 2];
  assign cfg_word_w.turnon_blank_sel = word_data[pfc_pkg::TON_LSB +: 2];
  assign cfg_word_w.shortbat_thresh_sel = word_data[pfc_pkg::SB_LSB +: 3];
  assign cfg_word_w.shortgnd_thresh_sel = word_data[pfc_pkg::SG_BIT];

  logic [N-1:0] gate_req_q;
  logic [N-1:0] mask_q;
  logic olm_q;

  always_ff @(posedge clk) begin
    if (!rst_n || clr_w) begin
      gate_req_q <= pfc_pkg::GATE_RESET;
      mask_q <= pfc_pkg::MASK_RESET;
      olm_q <= pfc_pkg::OLM_RESET;
    end else begin
      if (gate_we_w) begin
        gate_req_q <= word_data[N-1:0];
      end
      if (mask_we_w) begin
        mask_q <= word_data[N-1:0];
        olm_q <= word_data[pfc_pkg::OLM_BIT];
      end
    end
  end

  // Global sticky flags
  logic uv_q;
  logic ot_q;
  logic lr_q;

  always_ff @(posedge clk) begin
    if (!rst_n || clr_w) begin
      uv_q <= 1'b0;
      ot_q <= 1'b0;
    end else begin
      uv_q <= uv_q | uv_logic_s | uv_reg_s;
      ot_q <= ot_q | ot_s;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lr_q <= pfc_pkg::LR_RESET;
    end else if (clr_w) begin
      lr_q <= 1'b1;
    end else if (read_valid) begin
      lr_q <= 1'b0;
    end
  end

  // Per-channel configuration and fault logic
  pfc_pkg::pfc_cfg_s cfg_q [N];
  pfc_pkg::pfc_flags_s flags_w [N];
  logic [N-1:0] chan_fault_w;

  for (genvar i = 0; i < N; i++) begin : g_chan
    logic sel_w;
    logic [W-1:0] on_len_w;
    logic [W-1:0] off_len_w;
    logic [W-1:0] retry_len_w;
    pfc_pkg::pfc_flags_s cmp_w;

    assign sel_w = cfg_we_w & (adr_w == 3'(i));

    always_ff @(posedge clk) begin
      if (!rst_n || clr_w) begin
        cfg_q[i] <= '0;
      end else if (sel_w) begin
        cfg_q[i] <= cfg_word_w;
      end
    end

    assign on_len_w = TON_TAB[cfg_q[i].turnon_blank_sel];
    assign off_len_w = TOF_TAB[cfg_q[i].turnoff_blank_sel];
    assign retry_len_w = cfg_q[i].retry_select[0] ? RETRY_LONG_LEN : RETRY_SHORT_LEN;
    assign cmp_w.chan_short_gnd_flag = sg_s[i];
    assign cmp_w.chan_short_bat_flag = sb_s[i];
    assign cmp_w.chan_open_load_flag = ol_s[i];
    assign pulldown_en[i] = ~cfg_q[i].pulldown_disable;
    assign open_load_diag_en[i] = ~(olm_q & cfg_q[i].pulldown_disable);
    assign shortbat_thresh_sel[3*i +: 3] = cfg_q[i].shortbat_thresh_sel;
    assign shortgnd_thresh_sel[i] = cfg_q[i].shortgnd_thresh_sel;
    assign chan_fault_w[i] = |flags_w[i];

    pfc_chan #(.CW(W)) u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .clr(clr_w),
      .request(gate_req_q[i]),
      .enable(ext_rst_n_s),
      .mask(mask_q[i]),
      .ol_diag_en(open_load_diag_en[i]),
      .retry_mode(cfg_q[i].retry_select),
      .on_len(on_len_w),
      .off_len(off_len_w),
      .retry_len(retry_len_w),
      .cmp(cmp_w),
      .flags(flags_w[i]),
      .gate(driver_output[i])
    );
  end

  // Status words
  logic ff_w;
  pfc_pkg::pfc_status_s stat_lo_w;
  pfc_pkg::pfc_status_s stat_hi_w;
  logic [15:0] read_q;

  assign ff_w = uv_q | ot_q | (|chan_fault_w);
  assign stat_lo_w.fault_any_flag = ff_w;
  assign stat_lo_w.undervoltage_flag = uv_q;
  assign stat_lo_w.logic_reset_flag = lr_q;
  assign stat_lo_w.overtemp_flag = ot_q;
  assign stat_lo_w.fault_word_ident = 1'b0;
  assign stat_lo_w.zero = 2'b00;
  assign stat_lo_w.chans = {flags_w[2], flags_w[1], flags_w[0]};
  assign stat_hi_w.fault_any_flag = ff_w;
  assign stat_hi_w.undervoltage_flag = uv_q;
  assign stat_hi_w.logic_reset_flag = lr_q;
  assign stat_hi_w.overtemp_flag = ot_q;
  assign stat_hi_w.fault_word_ident = 1'b1;
  assign stat_hi_w.zero = 2'b00;
  assign stat_hi_w.chans = {flags_w[5], flags_w[4], flags_w[3]};

  // Word captured on the read strobe; held until the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_q <= 16'h0000;
    end else if (read_valid) begin
      read_q <= read_sel ? stat_hi_w : stat_lo_w;
    end
  end

  assign read_data = read_q;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  read_ff_a: assert property (read_valid |=> read_data[15] == $past(ff_w))
    else $error("Global fault bit wrong in read word");
  uv_latch_a: assert property ((uv_reg_s && ext_rst_n_s) |=> uv_q ##1 (uv_q || $past(clr_w)))
    else $error("Undervoltage flag not latched");
  lr_hold_a: assert property (clr_w ##1 (!clr_w && !read_valid) |-> lr_q)
    else $error("Logic reset flag lost before read");
  lr_clear_a: assert property ((read_valid && ext_rst_n_s && !clr_w) |=> !lr_q || clr_w)
    else $error("Logic reset flag not cleared by read");
  ot_latch_a: assert property ((ot_s && ext_rst_n_s) |=> ot_q)
    else $error("Overtemperature flag not latched");
  ident_bit_a: assert property (read_valid |=> read_data[11] == $past(read_sel))
    else $error("Identifier bit does not match word");
  cfg_write_a: assert property ((cfg_we_w && adr_w == 3'd5 && !clr_w)
    |=> cfg_q[5] == $past(cfg_word_w))
    else $error("Channel five not configured by write");
  cfg_addr_a: assert property ((cfg_we_w && adr_w == 3'd1 && !clr_w)
    |=> $stable(cfg_q[0]))
    else $error("Write to channel one touched channel zero");
  mask_quiet_a: assert property ((mask_q[1] && !clr_w) |-> flags_w[1] == '0
    ##1 $stable(g_chan[1].u_chan.flag_q))
    else $error("Masked channel reports a fault");
  gate_cause_a: assert property (driver_output[1] |-> $past(gate_req_q[1] && ext_rst_n_s))
    else $error("Gate driven without request");
  pin_clear_a: assert property (clr_w |=> cfg_q[0] == '0 && driver_output == 6'h00
    && !uv_q)
    else $error("Reset pin did not clear state");
  por_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> cfg_q[3] == '0 && lr_q)
    else $error("Power-on reset left configuration set");
  ol_mask_a: assert property ((olm_q && cfg_q[2].pulldown_disable)
    |-> !open_load_diag_en[2] ##1 (!flags_w[2].chan_open_load_flag || $past(flags_w[2]) != '0
    || clr_w || $past(clr_w) || !$past(olm_q)))
    else $error("Open-load diagnosis not masked");
  pd_map_a: assert property (pulldown_en[0] != cfg_q[0].pulldown_disable)
    else $error("Pull-down enable does not follow setting");
  sb_map_a: assert property (shortbat_thresh_sel[5:3] == cfg_q[1].shortbat_thresh_sel)
    else $error("Battery threshold select wrong");
  sg_map_a: assert property (shortgnd_thresh_sel[4] == cfg_q[4].shortgnd_thresh_sel)
    else $error("Ground threshold select wrong");
  uv_logic_a: assert property ((uv_logic_s && ext_rst_n_s) |=> uv_q)
    else $error("Logic supply undervoltage not latched");
  ff_idle_a: assert property (!ff_w |-> !uv_q && !ot_q && chan_fault_w == '0)
    else $error("Global fault flag missing");
  lr_set_a: assert property (clr_w |=> lr_q)
    else $error("Reset pin did not set logic reset flag");
  gate_clear_a: assert property (!ext_rst_n_s |=> driver_output == 6'h00)
    else $error("Gate driven while reset pin low");
  lock_hold_a: assert property ((!cfg_q[2].retry_select[1] && g_chan[2].u_chan.block_q
    && !clr_w) |=> !driver_output[2])
    else $error("Locked channel drove its gate");
  sb_trip_a: assert property ((driver_output[1] && g_chan[1].u_chan.settled_w && sb_s[1]
    && !mask_q[1] && !clr_w)
    |=> g_chan[1].u_chan.flag_q.chan_short_bat_flag ##1 !driver_output[1])
    else $error("Battery short not latched or gate not dropped");
  blank_on_a: assert property ($rose(driver_output[1])
    |-> g_chan[1].u_chan.blank_q == $past(g_chan[1].on_len_w) - W'(1))
    else $error("Turn-on blanking length wrong");
  blank_off_a: assert property (($fell(driver_output[4]) && !$past(clr_w) && $past(rst_n))
    |-> g_chan[4].u_chan.blank_q == $past(g_chan[4].off_len_w) - W'(1))
    else $error("Turn-off blanking length wrong");
  blank_quiet_a: assert property ((!g_chan[4].u_chan.settled_w && !clr_w)
    |=> $stable(g_chan[4].u_chan.flag_q))
    else $error("Fault taken during blanking");
  retry_back_a: assert property (($fell(g_chan[1].u_chan.block_q) && !$past(clr_w)
    && $past(rst_n) && gate_req_q[1] && ext_rst_n_s && !clr_w) |=> driver_output[1])
    else $error("Retrying channel did not drive again");

  cfg_seen_c: cover property (cfg_we_w ##1 read_valid);
  sb_fault_c: cover property ($rose(flags_w[0].chan_short_bat_flag));
  retry_c: cover property ($rose(flags_w[1].chan_short_bat_flag) ##[1:1000] driver_output[1]);
  hi_read_c: cover property (read_valid && read_sel && ff_w);
  lock_c: cover property ($rose(g_chan[2].u_chan.block_q));
endmodule

/* verilog/pfc_pkg.sv */
package pfc_pkg;
  localparam int N_CHAN = 6;
  localparam int CLK_NS = 20;
  localparam int CNT_W = 22;

  // Serial word layout
  localparam int CMD_BIT = 15;
  localparam int HDR_LSB = 12;
  localparam int ADR_LSB = 12;
  localparam logic [3:0] HDR_GATE = 4'h1;
  localparam logic [3:0] HDR_MASK = 4'h5;
  localparam int RT_LSB = 10;
  localparam int NPD_BIT = 8;
  localparam int TOF_LSB = 6;
  localparam int TON_LSB = 4;
  localparam int SB_LSB = 1;
  localparam int SG_BIT = 0;
  localparam int OLM_BIT = 6;

  // Reset values
  localparam logic [N_CHAN-1:0] GATE_RESET = 6'h00;
  localparam logic [N_CHAN-1:0] MASK_RESET = 6'h00;
  localparam logic OLM_RESET = 1'b0;
  localparam logic LR_RESET = 1'b1;

  // Nominal times in ns
  localparam int TON0_NS = 5000;
  localparam int TON1_NS = 14000;
  localparam int TON2_NS = 28000;
  localparam int TON3_NS = 56000;
  localparam int TOF0_NS = 80000;
  localparam int TOF1_NS = 140000;
  localparam int TOF2_NS = 280000;
  localparam int TOF3_NS = 4000000;
  localparam int RETRY_SHORT_NS = 10000000;
  localparam int RETRY_LONG_NS = 55000000;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int TON0_CYC = cyc_up(TON0_NS);
  localparam int TON1_CYC = cyc_up(TON1_NS);
  localparam int TON2_CYC = cyc_up(TON2_NS);
  localparam int TON3_CYC = cyc_up(TON3_NS);
  localparam int TOF0_CYC = cyc_up(TOF0_NS);
  localparam int TOF1_CYC = cyc_up(TOF1_NS);
  localparam int TOF2_CYC = cyc_up(TOF2_NS);
  localparam int TOF3_CYC = cyc_up(TOF3_NS);
  localparam int RETRY_SHORT_CYC = cyc_up(RETRY_SHORT_NS);
  localparam int RETRY_LONG_CYC = cyc_up(RETRY_LONG_NS);

  typedef struct packed {
    logic [1:0] retry_select;
    logic pulldown_disable;
    logic [1:0] turnoff_blank_sel;
    logic [1:0] turnon_blank_sel;
    logic [2:0] shortbat_thresh_sel;
    logic shortgnd_thresh_sel;
  } pfc_cfg_s;

  typedef struct packed {
    logic chan_short_gnd_flag;
    logic chan_short_bat_flag;
    logic chan_open_load_flag;
  } pfc_flags_s;

  typedef struct packed {
    logic fault_any_flag;
    logic undervoltage_flag;
    logic logic_reset_flag;
    logic overtemp_flag;
    logic fault_word_ident;
    logic [1:0] zero;
    pfc_flags_s [2:0] chans;
  } pfc_status_s;
endpackage

/* verilog/pfc_sync.sv */
module pfc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* verilog/pfc_chan.sv */
module pfc_chan #(
  parameter int CW = 22
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic request,
  input wire logic enable,
  input wire logic mask,
  input wire logic ol_diag_en,
  input wire logic [1:0] retry_mode,
  input wire logic [CW-1:0] on_len,
  input wire logic [CW-1:0] off_len,
  input wire logic [CW-1:0] retry_len,
  input wire pfc_pkg::pfc_flags_s cmp,
  output pfc_pkg::pfc_flags_s flags,
  output logic gate
);
  logic gate_q;
  logic gate_d;
  logic block_q;
  logic block_d;
  logic [CW-1:0] blank_q;
  logic [CW-1:0] blank_d;
  logic [CW-1:0] retry_q;
  logic [CW-1:0] retry_d;
  logic settled_w;
  logic retry_done_w;
  pfc_pkg::pfc_flags_s flag_q;
  pfc_pkg::pfc_flags_s hit_w;

  assign gate_d = request & enable & ~block_q;
  assign settled_w = (blank_q == '0);
  // Each transition restarts blanking with the new state's length
  assign blank_d = (gate_d != gate_q) ? ((gate_d ? on_len : off_len) - CW'(1))
                 : (settled_w ? blank_q : blank_q - CW'(1));
  // Battery short is an on-state check, the other two off-state
  assign hit_w.chan_short_bat_flag = gate_q & settled_w & cmp.chan_short_bat_flag & ~mask;
  assign hit_w.chan_short_gnd_flag = ~gate_q & settled_w & cmp.chan_short_gnd_flag & ~mask;
  assign hit_w.chan_open_load_flag = ~gate_q & settled_w & cmp.chan_open_load_flag
                                   & ol_diag_en & ~mask;
  assign retry_done_w = (retry_q == '0);
  assign retry_d = hit_w.chan_short_bat_flag ? retry_len - CW'(1)
                 : (retry_done_w ? retry_q : retry_q - CW'(1));
  // Upper retry bit clear means lockout until fault reset
  assign block_d = hit_w.chan_short_bat_flag ? 1'b1
                 : ((block_q & retry_mode[1] & retry_done_w) ? 1'b0 : block_q);
  assign flags = mask ? '0 : flag_q;
  assign gate = gate_q;

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      gate_q <= 1'b0;
      block_q <= 1'b0;
      blank_q <= '0;
      retry_q <= '0;
      flag_q <= '0;
    end else begin
      gate_q <= gate_d;
      block_q <= block_d;
      blank_q <= blank_d;
      retry_q <= retry_d;
      flag_q <= flag_q | hit_w;
    end
  end
endmodule

/* test/pfc_host_model.sv */
module pfc_host_model (
  input wire logic clk,
  output logic word_valid,
  output logic [15:0] word_data,
  output logic read_valid,
  output logic read_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    word_valid = 1'b0;
    word_data = 16'h0000;
    read_valid = 1'b0;
    read_sel = 1'b0;
  end

  // One-cycle strobe; data inverted after release so a stale word never looks valid
  task automatic write_word(input logic [15:0] w, input int gap);
    repeat (gap + 1) @(posedge clk);
    word_valid <= 1'b1;
    word_data <= w;
    @(posedge clk);
    word_valid <= 1'b0;
    word_data <= ~w;
  endtask

  task automatic read_word(input logic sel);
    @(posedge clk);
    read_valid <= 1'b1;
    read_sel <= sel;
    @(posedge clk);
    read_valid <= 1'b0;
    read_sel <= ~sel;
  endtask
endmodule

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, active_low_reset_in, uv_logic_in, uv_regulator_in, overtemp_in;
  logic [5:0] cmp_sg, cmp_sb, cmp_ol;
  logic word_valid, read_valid, read_sel;
  logic [15:0] word_data, read_data;
  logic [5:0] driver_output, pulldown_en, ol_diag_en, sg_sel;
  logic [17:0] sb_sel;
  int n_fail = 0;
  int checks = 0;
  int seed = 43;
  logic [15:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [5:0] exp_pd, exp_sg;
  logic [17:0] exp_sb;
  logic [11:0] r;

  pfc_host_model pfc_host_model_inst (.clk(clk), .word_valid(word_valid),
    .word_data(word_data), .read_valid(read_valid), .read_sel(read_sel));

  // Shortened long timers keep the run small
  pfc_top #(.TOF1_CYC(20), .TOF2_CYC(30), .TOF3_CYC(40), .RETRY_SHORT_CYC(50),
    .RETRY_LONG_CYC(80)) pfc_top_inst (
    .clk(clk), .rst_n(rst_n), .active_low_reset_in(active_low_reset_in),
    .word_valid(word_valid), .word_data(word_data), .read_valid(read_valid),
    .read_sel(read_sel), .read_data(read_data), .uv_logic_in(uv_logic_in),
    .uv_regulator_in(uv_regulator_in), .overtemp_in(overtemp_in),
    .cmp_short_gnd(cmp_sg), .cmp_short_bat(cmp_sb), .cmp_open_load(cmp_ol),
    .driver_output(driver_output), .pulldown_en(pulldown_en),
    .open_load_diag_en(ol_diag_en), .shortbat_thresh_sel(sb_sel),
    .shortgnd_thresh_sel(sg_sel));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Counts: checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] w);
    pfc_host_model_inst.write_word(w, 0);
  endtask

  // Expected word queued before the strobe; the monitor pairs it with the answer
  task automatic rd(input logic sel, input logic [15:0] e);
    exp_q.push_back(e);
    pfc_host_model_inst.read_word(sel);
    cyc(1);
  endtask

  task automatic tdone(input string s);
    $display("Test done: %s", s);
  endtask

  task automatic pin_reset();
    active_low_reset_in <= 1'b0;
    cyc(5);
    active_low_reset_in <= 1'b1;
    cyc(5);
  endtask

  // Answer stands from the edge after the request
  always @(posedge clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, read_data, 16'hxxxx);
      end else begin
        chk({2'b00, read_data}, {2'b00, exp_q.pop_front()});
      end
    end
    rd_pend <= read_valid;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    active_low_reset_in = 1'b1;
    {uv_logic_in, uv_regulator_in, overtemp_in} = 3'b000;
    {cmp_sg, cmp_sb, cmp_ol} = '0;
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    chk({12'h000, pulldown_en}, {12'h000, 6'h3F});
    chk(sb_sel, {6'h00, 12'h000});
    chk({12'h000, sg_sel | driver_output}, 18'h0);
    rd(1'b0, 16'h2000);
    rd(1'b1, 16'h0800);
    tdone("reset values");

    for (int ch = 0; ch < 6; ch++) begin
      r = 12'($random(seed));
      r[9] = 1'b0;
      wr({1'b1, 3'(ch), r});
      exp_pd[ch] = ~r[8];
      exp_sb[3*ch +: 3] = r[3:1];
      exp_sg[ch] = r[0];
    end
    wr(16'hEFFF);
    wr(16'hF000);
    wr(16'h2FFF);
    cyc(2);
    chk({12'h000, pulldown_en}, {12'h000, exp_pd});
    chk(sb_sel, exp_sb);
    chk({12'h000, sg_sel}, {12'h000, exp_sg});
    tdone("channel config");

    wr(16'h5040);
    cyc(2);
    chk({12'h000, ol_diag_en}, {12'h000, exp_pd});
    wr(16'h5000);
    cyc(2);
    chk({12'h000, ol_diag_en}, {12'h000, 6'h3F});
    tdone("open-load mask");

    uv_logic_in <= 1'b1;
    cyc(5);
    uv_logic_in <= 1'b0;
    cyc(5);
    rd(1'b0, 16'hC000);
    overtemp_in <= 1'b1;
    cyc(5);
    overtemp_in <= 1'b0;
    cyc(5);
    rd(1'b1, 16'hD800);
    pin_reset();
    chk({12'h000, pulldown_en}, {12'h000, 6'h3F});
    chk(sb_sel, {6'h00, 12'h000});
    rd(1'b0, 16'h2000);
    tdone("global flags and fault reset");

    // Ch1: short retry, shortest blanking
    wr({4'h9, 12'h840});
    wr(16'h1002);
    cyc(4);
    chk({12'h000, driver_output}, {12'h000, 6'h02});
    cyc(300);
    cmp_sb[1] <= 1'b1;
    cyc(6);
    cmp_sb[1] <= 1'b0;
    chk({12'h000, driver_output}, {12'h000, 6'h00});
    rd(1'b0, 16'h8010);
    cyc(20);
    chk({12'h000, driver_output}, {12'h000, 6'h00});
    for (int i = 0; i < 300 && driver_output[1] !== 1'b1; i++) begin
      cyc(1);
    end
    chk({17'h0, driver_output[1]}, 18'h1);
    wr(16'h5002);
    cyc(2);
    rd(1'b0, 16'h0000);
    tdone("battery short with retry");

    // Ch2: lockout
    wr({4'hA, 12'h040});
    wr(16'h1006);
    cyc(300);
    cmp_sb[2] <= 1'b1;
    cyc(10);
    cmp_sb[2] <= 1'b0;
    cyc(300);
    chk({17'h0, driver_output[2]}, 18'h0);
    rd(1'b0, 16'h8080);
    tdone("battery short lockout");

    // Ch4: faults seen only while off
    wr({4'hC, 12'h040});
    wr(16'h1016);
    cyc(10);
    wr(16'h1006);
    cyc(60);
    cmp_sg[4] <= 1'b1;
    cmp_ol[4] <= 1'b1;
    uv_regulator_in <= 1'b1;
    cyc(8);
    {cmp_sg[4], cmp_ol[4], uv_regulator_in} <= 3'b000;
    cyc(5);
    rd(1'b1, 16'hC828);
    rd(1'b0, 16'hC080);
    tdone("ground short and open load");
    cyc(5);
    close_out();
  end
endmodule
